// ---- common/bit_op_pkg.sv ----
// Types shared by the bit-op unit: sequencer states and decoded instruction kinds.
package bit_op_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_IDLE_CYC} seq_state_type;
  typedef enum logic [2:0] {OP_NONE, OP_TOGGLE, OP_SKIP_CLR, OP_SKIP_SET, OP_BOV} op_kind_type;
endpackage : bit_op_pkg

// ---- common/bit_op_regs.svh ----
// Register offsets, field positions, opcode patterns and reset values of the bit-op unit.
`ifndef BIT_OP_REGS_SVH
`define BIT_OP_REGS_SVH
`define OFS_INSTR 8'h00
`define OFS_CTRL 8'h04
`define OFS_BANK 8'h08
`define OFS_PC 8'h0C
`define OFS_IDX 8'h10
`define OFS_STAT 8'h14
`define CTRL_EXT_BIT 0
`define CTRL_OVF_BIT 1
`define CTRL_TWO_WORD_BIT 2
`define STAT_BUSY_BIT 0
`define STAT_SKIP_BIT 1
`define STAT_BRANCH_BIT 2
`define STAT_UNKNOWN_BIT 3
`define OPC_TOGGLE 4'h7
`define OPC_SKIP_CLR 4'hB
`define OPC_SKIP_SET 4'hA
`define OPC_BRANCH_OVF 8'hE4
`define IDX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_PAGE 4'hF
`define ACCESS_LOW_PAGE 4'h0
`define Q_LAST 2'h3
`define PC_STEP 21'h000002
`define RST_PC 21'h000000
`define RST_INSTR 16'h0000
`endif

// ---- hdl/bit_op_branch_decode.sv ----
// Bit test-and-skip, bit toggle and branch-on-overflow execution unit with an AHB-Lite slave.
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "bit_op_regs.svh"
module bit_op_branch_decode
  import bit_op_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [11:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  input wire logic [7:0] dmem_rdata
);
  seq_state_type state_ff, nxt_state;
  op_kind_type op_kind;
  logic [1:0] q_ff, nop_left_ff, nxt_nop_left;
  logic [15:0] instr_ff;
  logic [3:0] bank_ff;
  logic [20:0] pc_ff, nxt_pc;
  logic [11:0] idx_ff;
  logic ext_ff, ovf_ff, two_word_ff, form_indexed;
  logic skip_ff, branch_ff, unknown_ff;
  logic [7:0] data_ff;
  logic [3:0] cycles_ff;
  logic [7:0] ad_ofs_ff;
  logic ad_wr_ff, ad_pend_ff;
  logic hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff;
  logic [11:0] dmem_addr_ff, form_addr;
  logic dmem_rd_ff, dmem_wr_ff;
  logic [7:0] dmem_wdata_ff;

  wire busy = (state_ff != ST_IDLE);
  wire ad_take = hsel && htrans[1] && hready;
  wire wr_now = ad_pend_ff && ad_wr_ff;
  wire start = wr_now && (ad_ofs_ff == `OFS_INSTR) && !busy;
  wire q_end = (q_ff == `Q_LAST);
  wire end_exec = (state_ff == ST_EXEC) && q_end;
  wire [2:0] bit_idx = instr_ff[11:9];
  wire [7:0] bit_mask = 8'h01 << bit_idx;
  wire tested_bit = data_ff[bit_idx];
  wire [7:0] offset_n = instr_ff[7:0];
  wire [20:0] branch_target = pc_ff + `PC_STEP + {{12{offset_n[7]}}, offset_n, 1'b0};
  wire skip_now = ((op_kind == OP_SKIP_CLR) && !tested_bit) ||
                  ((op_kind == OP_SKIP_SET) && tested_bit);
  wire branch_now = (op_kind == OP_BOV) && ovf_ff;
  wire [20:0] skip_target = pc_ff + `PC_STEP + (two_word_ff ? 21'h000004 : `PC_STEP);

  // Decode of the held opcode; the skip pair differs only in the polarity of the test.
  assign op_kind = (instr_ff[15:12] == `OPC_TOGGLE) ? OP_TOGGLE :
                   (instr_ff[15:12] == `OPC_SKIP_CLR) ? OP_SKIP_CLR :
                   (instr_ff[15:12] == `OPC_SKIP_SET) ? OP_SKIP_SET :
                   (instr_ff[15:8] == `OPC_BRANCH_OVF) ? OP_BOV : OP_NONE;

  file_addr_former u_addr (
    .bank_bit(instr_ff[8]),
    .file_addr(instr_ff[7:0]),
    .bank_sel(bank_ff),
    .ext_en(ext_ff),
    .idx_base(idx_ff),
    .mem_addr(form_addr),
    .indexed(form_indexed)
  );

  // Sequencer next state: one instruction cycle of four quarters, then idle cycles if needed.
  always_comb begin
    nxt_state = state_ff;
    nxt_nop_left = nop_left_ff;
    nxt_pc = pc_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (q_end) begin
          nxt_state = ST_IDLE;
          nxt_pc = pc_ff + `PC_STEP;
          if (skip_now) begin
            nxt_state = ST_IDLE_CYC;
            nxt_nop_left = two_word_ff ? 2'h1 : 2'h0;
            nxt_pc = skip_target;
          end else if (branch_now) begin
            nxt_state = ST_IDLE_CYC;
            nxt_nop_left = 2'h0;
            nxt_pc = branch_target;
          end
        end
      end
      ST_IDLE_CYC: begin
        if (q_end) begin
          if (nop_left_ff == 2'h0) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_nop_left = nop_left_ff - 2'h1;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers; the quarter counter restarts with every instruction.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      q_ff <= 2'h0;
      nop_left_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      nop_left_ff <= nxt_nop_left;
      q_ff <= (busy && !(end_exec && nxt_state == ST_IDLE)) ? q_ff + 2'h1 : 2'h0;
    end
  end

  // Quarter-phase memory traffic: address in Q1, read in Q2, modify in Q3, write in Q4.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dmem_addr_ff <= 12'h000;
      dmem_rd_ff <= 1'b0;
      dmem_wr_ff <= 1'b0;
      dmem_wdata_ff <= 8'h00;
      data_ff <= 8'h00;
    end else begin
      dmem_rd_ff <= (state_ff == ST_EXEC) && (q_ff == 2'h0) && (op_kind != OP_BOV);
      dmem_wr_ff <= (state_ff == ST_EXEC) && (q_ff == 2'h2) && (op_kind == OP_TOGGLE);
      if ((state_ff == ST_EXEC) && (q_ff == 2'h0)) begin
        dmem_addr_ff <= form_addr;
      end
      if (dmem_rd_ff) begin
        data_ff <= dmem_rdata;
      end
      if ((state_ff == ST_EXEC) && (q_ff == 2'h2)) begin
        dmem_wdata_ff <= dmem_rdata ^ bit_mask;
      end
    end
  end

  // Result flags and program counter; no status flag of the core is touched here.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_ff <= `RST_PC;
      skip_ff <= 1'b0;
      branch_ff <= 1'b0;
      unknown_ff <= 1'b0;
      cycles_ff <= 4'h0;
    end else begin
      if (!busy && wr_now && (ad_ofs_ff == `OFS_PC)) begin
        pc_ff <= hwdata[20:0];
      end else begin
        pc_ff <= nxt_pc;
      end
      if (start) begin
        cycles_ff <= 4'h0;
      end else if (busy && q_end) begin
        cycles_ff <= cycles_ff + 4'h1;
      end
      if (end_exec) begin
        skip_ff <= skip_now;
        branch_ff <= branch_now;
        unknown_ff <= (op_kind == OP_NONE);
      end
    end
  end

  // Software-written control state; opcode and PC writes are refused while busy.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_ff <= `RST_INSTR;
      bank_ff <= 4'h0;
      idx_ff <= 12'h000;
      ext_ff <= 1'b0;
      ovf_ff <= 1'b0;
      two_word_ff <= 1'b0;
    end else if (wr_now) begin
      if (start) begin
        instr_ff <= hwdata[15:0];
      end
      if (ad_ofs_ff == `OFS_CTRL) begin
        ext_ff <= hwdata[`CTRL_EXT_BIT];
        ovf_ff <= hwdata[`CTRL_OVF_BIT];
        two_word_ff <= hwdata[`CTRL_TWO_WORD_BIT];
      end
      if (ad_ofs_ff == `OFS_BANK) begin
        bank_ff <= hwdata[3:0];
      end
      if (ad_ofs_ff == `OFS_IDX) begin
        idx_ff <= hwdata[11:0];
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  wire [31:0] rd_val = (ad_ofs_ff == `OFS_INSTR) ? {16'h0000, instr_ff} :
                       (ad_ofs_ff == `OFS_CTRL) ? {29'h0, two_word_ff, ovf_ff, ext_ff} :
                       (ad_ofs_ff == `OFS_BANK) ? {28'h0, bank_ff} :
                       (ad_ofs_ff == `OFS_PC) ? {11'h000, pc_ff} :
                       (ad_ofs_ff == `OFS_IDX) ? {20'h00000, idx_ff} :
                       (ad_ofs_ff == `OFS_STAT) ? {24'h0, cycles_ff, unknown_ff, branch_ff,
                                                   skip_ff, busy} : 32'h0000_0000;

  // Bus slave: every transfer gets one wait state so that read data comes from a flop.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ad_ofs_ff <= 8'h00;
      ad_wr_ff <= 1'b0;
      ad_pend_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      ad_pend_ff <= ad_take && hreadyout_ff;
      hreadyout_ff <= !(ad_take && hreadyout_ff);
      if (ad_take && hreadyout_ff) begin
        ad_ofs_ff <= haddr[7:0] & 8'hFC;
        ad_wr_ff <= hwrite && (haddr[31:8] == 24'h000000);
      end
      if (ad_pend_ff && !ad_wr_ff) begin
        hrdata_ff <= rd_val;
      end
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign dmem_addr = dmem_addr_ff;
  assign dmem_rd = dmem_rd_ff;
  assign dmem_wr = dmem_wr_ff;
  assign dmem_wdata = dmem_wdata_ff;

  // Checks of the execution sequence against the decoded instruction.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_skip_clr;
    end_exec && op_kind == OP_SKIP_CLR |=> (state_ff == ST_IDLE_CYC) == !$past(tested_bit);
  endproperty
  a_skip_clr: assert property (p_skip_clr) else $error("skip-if-clear wrong");
  property p_skip_set;
    end_exec && op_kind == OP_SKIP_SET |=> (state_ff == ST_IDLE_CYC) == $past(tested_bit);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip-if-set wrong");
  property p_toggle_data;
    state_ff == ST_EXEC && q_ff == 2'h2 && op_kind == OP_TOGGLE
      |=> dmem_wr_ff && dmem_wdata_ff == ($past(dmem_rdata) ^ $past(bit_mask));
  endproperty
  a_toggle_data: assert property (p_toggle_data) else $error("toggle data wrong");
  property p_bank_addr;
    state_ff == ST_EXEC && q_ff == 2'h1 && instr_ff[8] |-> dmem_addr_ff == {bank_ff,instr_ff[7:0]};
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");
  property p_indexed;
    state_ff == ST_EXEC && q_ff == 2'h1 && ext_ff && !instr_ff[8] && instr_ff[7:0] <= `IDX_LIMIT
      |-> dmem_addr_ff == idx_ff + {4'h0, instr_ff[7:0]};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");
  property p_branch_pc;
    end_exec && op_kind == OP_BOV && ovf_ff |=> pc_ff == $past(branch_target);
  endproperty
  a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");
  property p_toggle_len;
    state_ff == ST_IDLE && start && hwdata[15:12] == `OPC_TOGGLE
      |=> (state_ff == ST_EXEC) [*4] ##1 state_ff == ST_IDLE;
  endproperty
  a_toggle_len: assert property (p_toggle_len) else $error("toggle length wrong");
  property p_skip_two;
    end_exec && skip_now && two_word_ff |=> (state_ff == ST_IDLE_CYC) [*8] ##1 state_ff == ST_IDLE;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip length wrong");
  property p_branch_len;
    end_exec && branch_now |=> (state_ff == ST_IDLE_CYC) [*4] ##1 state_ff == ST_IDLE;
  endproperty
  a_branch_len: assert property (p_branch_len) else $error("branch length wrong");
  c_toggle: cover property (dmem_wr_ff);
  c_skip: cover property (end_exec && skip_now && !two_word_ff);
  c_branch: cover property (end_exec && branch_now && offset_n[7]);
  c_indexed: cover property (state_ff == ST_EXEC && q_ff == 2'h0 && form_indexed);
endmodule : bit_op_branch_decode

// ---- hdl/file_addr_former.sv ----
// Forms the 12-bit data memory address of a file operand from bank bit and file address.
`timescale 1ns/1ps
`include "bit_op_regs.svh"
module file_addr_former (
  input wire logic bank_bit,
  input wire logic [7:0] file_addr,
  input wire logic [3:0] bank_sel,
  input wire logic ext_en,
  input wire logic [11:0] idx_base,
  output logic [11:0] mem_addr,
  output logic indexed
);
  logic [11:0] access_addr;

  // Indexed mode only covers the low part of the access bank, so high file registers stay fixed.
  assign indexed = ext_en && !bank_bit && (file_addr <= `IDX_LIMIT);
  assign access_addr = (file_addr >= `ACCESS_SPLIT) ? {`ACCESS_HIGH_PAGE, file_addr} :
                       {`ACCESS_LOW_PAGE, file_addr};
  assign mem_addr = indexed ? idx_base + {4'h0, file_addr} :
                    bank_bit ? {bank_sel, file_addr} : access_addr;
endmodule : file_addr_former

// ---- tb/data_mem_model.sv ----
// Behavioural data memory that stands on the far side of the bit-op unit.
`timescale 1ns/1ps
module data_mem_model (
  input wire logic ref_clk,
  input wire logic [11:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [7:0] dmem_wdata,
  output logic [7:0] dmem_rdata
);
  logic [7:0] mem [0:4095];
  logic rd_ff;
  logic [7:0] last_ff;
  initial begin
    rd_ff = 1'b0;
    last_ff = 8'h00;
  end
  // Data is valid in the read cycle and the cycle after; otherwise the bus shows stale garbage.
  assign dmem_rdata = (dmem_rd | rd_ff) ? mem[dmem_addr] : ~last_ff;
  // Plain always so the bench may preload bytes hierarchically without a second driver clash.
  always @(posedge ref_clk) begin
    rd_ff <= dmem_rd;
    if (dmem_rd | rd_ff) last_ff <= dmem_rdata;
    if (dmem_wr) mem[dmem_addr] <= dmem_wdata;
  end
endmodule : data_mem_model

// ---- tb/tb.sv ----
// Self-checking bench for the bit-op unit, driven over AHB-Lite.
`timescale 1ns/1ps
`include "bit_op_regs.svh"
module tb;
  logic ref_clk, reset_n, hsel, hwrite, hreadyout, hresp, dmem_rd, dmem_wr;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [11:0] dmem_addr;
  logic [7:0] dmem_wdata, dmem_rdata;
  int mismatches, checks, cycles;

  // The slave is alone on the bus, so its hreadyout is the bus hready.
  bit_op_branch_decode DUT (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));
  data_mem_model mem_i (.ref_clk(ref_clk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // A hang is cut short well after the few hundred cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results;
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk

  // Single word transfer: hold the address phase until hready, then the data phase likewise.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Runs one instruction from a given PC and judges PC, result flags and cycle count.
  task run(input logic [20:0] pc0, input logic [15:0] op, input logic [20:0] pc_exp,
           input logic [3:0] cyc, input logic [1:0] flg);
    logic [31:0] r;
    int n;
    bus(1'b1, `OFS_PC, {11'h000, pc0}, r);
    bus(1'b1, `OFS_INSTR, {16'h0000, op}, r);
    n = 0;
    do begin
      bus(1'b0, `OFS_STAT, 32'h00000000, r);
      n++;
    end while (r[`STAT_BUSY_BIT] !== 1'b0 && n < 30);
    chk("cycles", {28'h0000000, cyc}, {28'h0000000, r[7:4]});
    chk("flags", {30'h00000000, flg}, {30'h00000000, r[2:1]});
    bus(1'b0, `OFS_PC, 32'h00000000, r);
    chk("pc", {11'h000, pc_exp}, r);
  endtask : run

  task t_reset;
    logic [31:0] r;
    bus(1'b0, `OFS_PC, 32'h00000000, r);
    chk("pc reset", 32'h00000000, r);
    bus(1'b0, 8'h18, 32'h00000000, r);
    chk("unmapped", 32'h00000000, r);
    chk("hresp", 32'h00000000, {31'h00000000, hresp});
    // An opcode outside the group still takes one cycle and raises the unknown flag.
    run(21'h000300, 16'h0000, 21'h000302, 4'h1, 2'b00);
    bus(1'b0, `OFS_STAT, 32'h00000000, r);
    chk("unknown", 32'h00000001, {31'h00000000, r[`STAT_UNKNOWN_BIT]});
    $display("test reset done");
  endtask : t_reset

  task t_toggle;
    logic [31:0] r;
    bus(1'b1, `OFS_CTRL, 32'h00000002, r);
    bus(1'b1, `OFS_BANK, 32'h00000003, r);
    mem_i.mem[12'h3A5] = 8'h75;
    mem_i.mem[12'hF80] = 8'h01;
    mem_i.mem[12'h010] = 8'h80;
    run(21'h000100, 16'h79A5, 21'h000102, 4'h1, 2'b00);
    chk("banked", 32'h00000065, {24'h000000, mem_i.mem[12'h3A5]});
    bus(1'b0, `OFS_STAT, 32'h00000000, r);
    chk("known", 32'h00000000, {31'h00000000, r[`STAT_UNKNOWN_BIT]});
    run(21'h000100, 16'h7080, 21'h000102, 4'h1, 2'b00);
    chk("access high", 32'h00000000, {24'h000000, mem_i.mem[12'hF80]});
    run(21'h000100, 16'h7E10, 21'h000102, 4'h1, 2'b00);
    chk("access low", 32'h00000000, {24'h000000, mem_i.mem[12'h010]});
    bus(1'b0, `OFS_CTRL, 32'h00000000, r);
    chk("ctrl kept", 32'h00000002, r);
    $display("test toggle done");
  endtask : t_toggle

  task t_indexed;
    logic [31:0] r;
    bus(1'b1, `OFS_CTRL, 32'h00000001, r);
    bus(1'b1, `OFS_IDX, 32'h00000200, r);
    mem_i.mem[12'h25F] = 8'h0F;
    mem_i.mem[12'hF60] = 8'h00;
    run(21'h000010, 16'h705F, 21'h000012, 4'h1, 2'b00);
    chk("indexed", 32'h0000000E, {24'h000000, mem_i.mem[12'h25F]});
    run(21'h000010, 16'h7260, 21'h000012, 4'h1, 2'b00);
    chk("not indexed", 32'h00000002, {24'h000000, mem_i.mem[12'hF60]});
    $display("test indexed done");
  endtask : t_indexed

  // The byte holds bit 1 set and bit 0 clear, so each opcode meets both outcomes.
  task t_skip;
    logic [31:0] r;
    bus(1'b1, `OFS_CTRL, 32'h00000000, r);
    mem_i.mem[12'h020] = 8'h02;
    run(21'h000200, 16'hB020, 21'h000204, 4'h2, 2'b01);
    run(21'h000200, 16'hB220, 21'h000202, 4'h1, 2'b00);
    run(21'h000200, 16'hA220, 21'h000204, 4'h2, 2'b01);
    run(21'h000200, 16'hA020, 21'h000202, 4'h1, 2'b00);
    bus(1'b1, `OFS_CTRL, 32'h00000004, r);
    run(21'h000200, 16'hA220, 21'h000206, 4'h3, 2'b01);
    $display("test skip done");
  endtask : t_skip

  task t_branch;
    logic [31:0] r;
    bus(1'b1, `OFS_CTRL, 32'h00000002, r);
    run(21'h001000, 16'hE480, 21'h000F02, 4'h2, 2'b10);
    run(21'h001000, 16'hE47F, 21'h001100, 4'h2, 2'b10);
    bus(1'b1, `OFS_CTRL, 32'h00000000, r);
    run(21'h001000, 16'hE47F, 21'h001002, 4'h1, 2'b00);
    $display("test branch done");
  endtask : t_branch

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_toggle;
    t_indexed;
    t_skip;
    t_branch;
    results;
  end
endmodule : tb
